// ---- core/vsp_clkdiv.sv ----
// Bit clock divider used while the port is clock master.
`timescale 1ns/1ps
module vsp_clkdiv #(
	parameter int CW = 12
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic [CW-1:0] i_half,
	output logic o_bclk
);
	import vsp_pkg::*;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic bclk_q;
	logic bclk_d;

	always_comb
	begin
		cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
		bclk_d = bclk_q;
		if (!i_run)
		begin
			cnt_d = '0;
			bclk_d = 1'b0;
		end
		else if (cnt_q + {{(CW-1){1'b0}}, 1'b1} >= i_half)
		begin
			cnt_d = '0;
			bclk_d = ~bclk_q;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			cnt_q <= '0;
			bclk_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			bclk_q <= bclk_d;
		end
	end

	assign o_bclk = bclk_q;

endmodule : vsp_clkdiv

// ---- core/vsp_port.sv ----
// Voice serial port: register file, master clocking and the serial link engine.
// What this block does
// - Signalling follows the I2S bus conventions.
// - Four lines: clock, frame sync, rx, tx.
// - Master mode generates bit clock and frame sync.
// - Slave mode takes both from codec, undriven.
// - Enable: 0 off, 1 on, 2 reserved.
// - Port select 1 by default, 2 reserved.
// - Clock role: 0 slave, 1 master default.
// - Role is set before a call, codec complementary.
// - Normal format frame sync marks left/right channel.
// - Burst format frame sync marks frame start.
// - Normal edge 0: launch falling, capture rising.
// - Burst: launch rising, capture falling, either edge.
`timescale 1ns/1ps
`include "vsp_consts.svh"
module vsp_port #(
	parameter int CLK_HZ = `VSP_CLK_HZ
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_bclk,
	output logic o_bclk,
	output logic o_bclk_oe,
	input wire logic i_fsync,
	output logic o_fsync,
	output logic o_fsync_oe,
	input wire logic i_rx,
	output logic o_tx,
	output logic o_tx_oe
);
	import vsp_pkg::*;

	// ****************************************************************
	// Master clock half periods
	// ****************************************************************
	localparam int HN16 = CLK_HZ / (4 * `VSP_SAMPLE_HZ * 16);
	localparam int HN24 = CLK_HZ / (4 * `VSP_SAMPLE_HZ * 24);
	localparam int HN32 = CLK_HZ / (4 * `VSP_SAMPLE_HZ * 32);
	localparam int HB16 = CLK_HZ / (2 * `VSP_SAMPLE_HZ * 16);
	localparam int HB24 = CLK_HZ / (2 * `VSP_SAMPLE_HZ * 24);
	localparam int HB32 = CLK_HZ / (2 * `VSP_SAMPLE_HZ * 32);

	// ****************************************************************
	// System domain state
	// ****************************************************************
	vsp_en_t en_q, en_d;
	logic [1:0] port_q, port_d;
	logic master_q, master_d;
	logic burst_q, burst_d;
	logic edge_q, edge_d;
	vsp_wsel_t wsel_q, wsel_d;
	logic [31:0] txdata_q, txdata_d;
	logic tx_tgl_q, tx_tgl_d;
	logic [31:0] rxdata_q, rxdata_d;
	logic rx_new_q, rx_new_d;
	logic rx_seen_q, rx_seen_d;
	logic [31:0] rdata_q, rdata_d;
	logic active_q, active_d;
	logic bclk_oe_q, bclk_oe_d;
	logic tx_oe_q, tx_oe_d;
	logic [11:0] half;
	logic rx_tgl_s;
	logic rx_arrive;
	logic bclk_gen;

	// Link domain signals
	logic lclk;
	logic lk_act, lk_master, lk_burst, lk_tgl;
	logic [2:0] lk_wsel;
	vsp_cnt_t w, nm1;
	vsp_cnt_t cnt_q, cnt_d;
	vsp_cnt_t idx;
	logic tx_q, tx_d;
	logic fs_q, fs_d;
	logic fs_prev_q, fs_prev_d;
	logic tgl_prev_q, tgl_prev_d;
	logic [31:0] tx_hold_q, tx_hold_d;
	logic [31:0] tx_frame_q, tx_frame_d;
	logic fs_edge;
	vsp_cnt_t cnt_free;
	logic [31:0] rx_sh_q, rx_sh_d;
	logic [31:0] rx_hold_q, rx_hold_d;
	logic rx_tgl_q, rx_tgl_d;
	logic fs_cap_q, fs_cap_d;
	logic [31:0] rx_next;

	// ****************************************************************
	// Register file
	// ****************************************************************
	always_comb
	begin
		en_d = en_q;
		port_d = port_q;
		master_d = master_q;
		burst_d = burst_q;
		edge_d = edge_q;
		wsel_d = wsel_q;
		txdata_d = txdata_q;
		tx_tgl_d = tx_tgl_q;
		if (i_wr && i_addr == `VSP_OFF_CTRL)
		begin
			en_d = vsp_en_t'(i_wdata[`VSP_CTRL_EN_LSB +: 2]);
			port_d = i_wdata[`VSP_CTRL_PORT_LSB +: 2];
			master_d = i_wdata[`VSP_CTRL_ROLE_BIT];
		end
		if (i_wr && i_addr == `VSP_OFF_FORMAT)
		begin
			burst_d = i_wdata[`VSP_FMT_BURST_BIT];
			edge_d = i_wdata[`VSP_FMT_EDGE_BIT];
			wsel_d = vsp_wsel_t'(i_wdata[`VSP_FMT_WSEL_LSB +: 3]);
		end
		if (i_wr && i_addr == `VSP_OFF_TXDATA)
		begin
			txdata_d = i_wdata;
			tx_tgl_d = ~tx_tgl_q;
		end
		// Reserved enable or port codes keep the port off.
		active_d = (en_q == VSP_EN_ON) && (port_q == 2'h1);
		bclk_oe_d = active_q && master_q;
		tx_oe_d = active_q;
		// A toggle that only returns the link to rest after disable is not a word.
		rx_arrive = active_q && (rx_tgl_s != rx_seen_q);
		rx_seen_d = rx_tgl_s;
		rxdata_d = rx_arrive ? rx_hold_q : rxdata_q;
		// A word arriving with the read of the data register still raises the flag.
		rx_new_d = rx_arrive || (rx_new_q && !(i_rd && i_addr == `VSP_OFF_RXDATA));
		rdata_d = 32'h0;
		if (i_rd)
		begin
			unique case (i_addr)
				`VSP_OFF_CTRL: rdata_d = {27'h0, master_q, port_q, en_q};
				`VSP_OFF_FORMAT: rdata_d = {27'h0, wsel_q, edge_q, burst_q};
				`VSP_OFF_TXDATA: rdata_d = txdata_q;
				`VSP_OFF_RXDATA: rdata_d = rxdata_q;
				`VSP_OFF_STATUS: rdata_d = {30'h0, rx_new_q, active_q};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			en_q <= vsp_en_t'(`VSP_RST_EN);
			port_q <= `VSP_RST_PORT;
			master_q <= `VSP_RST_ROLE;
			burst_q <= `VSP_RST_BURST;
			edge_q <= `VSP_RST_EDGE;
			wsel_q <= vsp_wsel_t'(`VSP_RST_WSEL);
			txdata_q <= 32'h0;
			tx_tgl_q <= 1'b0;
			rxdata_q <= 32'h0;
			rx_new_q <= 1'b0;
			rx_seen_q <= 1'b0;
			rdata_q <= 32'h0;
			active_q <= 1'b0;
			bclk_oe_q <= 1'b0;
			tx_oe_q <= 1'b0;
		end
		else
		begin
			en_q <= en_d;
			port_q <= port_d;
			master_q <= master_d;
			burst_q <= burst_d;
			edge_q <= edge_d;
			wsel_q <= wsel_d;
			txdata_q <= txdata_d;
			tx_tgl_q <= tx_tgl_d;
			rxdata_q <= rxdata_d;
			rx_new_q <= rx_new_d;
			rx_seen_q <= rx_seen_d;
			rdata_q <= rdata_d;
			active_q <= active_d;
			bclk_oe_q <= bclk_oe_d;
			tx_oe_q <= tx_oe_d;
		end
	end

	// ****************************************************************
	// Master bit clock
	// ****************************************************************
	always_comb
	begin
		unique case ({burst_q, wsel_q})
			{1'b0, VSP_W24}: half = 12'(HN24);
			{1'b0, VSP_W32}: half = 12'(HN32);
			{1'b1, VSP_W16}: half = 12'(HB16);
			{1'b1, VSP_W24}: half = 12'(HB24);
			{1'b1, VSP_W32}: half = 12'(HB32);
			default: half = 12'(HN16);
		endcase
	end

	vsp_clkdiv #(
		.CW(12)
	) u_div (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_run(bclk_oe_q),
		.i_half(half),
		.o_bclk(bclk_gen)
	);

	vsp_sync #(
		.WIDTH(1)
	) u_rx_sync (
		.i_clk(i_clk),
		.i_d(rx_tgl_q),
		.o_q(rx_tgl_s)
	);

	// ****************************************************************
	// Link engine
	// ****************************************************************
	// The link always runs on the bus clock as seen at the pin, so master and slave
	// share one path. Inverting it makes the capture edge the rising edge of lclk.
	// Format and edge must only change while the port is off, or the clock glitches.
	assign lclk = i_bclk ^ (burst_q | edge_q);

	vsp_sync #(
		.WIDTH(6)
	) u_cfg_sync (
		.i_clk(lclk),
		.i_d({active_q, master_q, burst_q, wsel_q}),
		.o_q({lk_act, lk_master, lk_burst, lk_wsel})
	);

	vsp_sync #(
		.WIDTH(1)
	) u_tx_sync (
		.i_clk(lclk),
		.i_d(tx_tgl_q),
		.o_q(lk_tgl)
	);

	// Launch side, falling edge of lclk.
	always_comb
	begin
		w = (lk_wsel == VSP_W24) ? 6'd24 : (lk_wsel == VSP_W32) ? 6'd32 : 6'd16;
		nm1 = lk_burst ? (w - 6'h1) : ({w[4:0], 1'b0} - 6'h1);
		cnt_free = (cnt_q == nm1) ? 6'h0 : (cnt_q + 6'h1);
		fs_prev_d = fs_cap_q;
		fs_edge = lk_burst ? (fs_cap_q && !fs_prev_q) : (fs_cap_q != fs_prev_q);
		if (!lk_act)
			cnt_d = 6'h0;
		else if (!lk_master && fs_edge)
			cnt_d = (!lk_burst && fs_cap_q) ? w : 6'h0;
		else
			cnt_d = cnt_free;
		tgl_prev_d = lk_tgl;
		// The word register is stable well before its toggle arrives here.
		tx_hold_d = (lk_tgl != tgl_prev_q) ? txdata_q : tx_hold_q;
		tx_frame_d = (cnt_d == 6'h0) ? tx_hold_q : tx_frame_q;
		idx = (cnt_d >= w) ? (cnt_d - w) : cnt_d;
		tx_d = lk_act && tx_frame_d[5'(w - 6'h1 - idx)];
		if (!lk_act || !lk_master)
			fs_d = 1'b0;
		else if (lk_burst)
			fs_d = cnt_d == nm1;
		else
			fs_d = (cnt_d >= w - 6'h1) && (cnt_d != nm1);
	end

	always_ff @(negedge lclk)
	begin
		cnt_q <= cnt_d;
		tx_q <= tx_d;
		fs_q <= fs_d;
		fs_prev_q <= fs_prev_d;
		tgl_prev_q <= tgl_prev_d;
		tx_hold_q <= tx_hold_d;
		tx_frame_q <= tx_frame_d;
	end

	// Capture side, rising edge of lclk.
	always_comb
	begin
		rx_next = {rx_sh_q[30:0], i_rx};
		rx_sh_d = lk_act ? rx_next : 32'h0;
		fs_cap_d = lk_act && i_fsync;
		rx_hold_d = rx_hold_q;
		rx_tgl_d = lk_act ? rx_tgl_q : 1'b0;
		// Only the first slot is returned; dual mono repeats it in the second.
		if (lk_act && cnt_q == w - 6'h1)
		begin
			rx_hold_d = rx_next & (32'hFFFFFFFF >> 5'(6'h20 - w));
			rx_tgl_d = ~rx_tgl_q;
		end
	end

	always_ff @(posedge lclk)
	begin
		rx_sh_q <= rx_sh_d;
		fs_cap_q <= fs_cap_d;
		rx_hold_q <= rx_hold_d;
		rx_tgl_q <= rx_tgl_d;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_rdata = rdata_q;
	assign o_bclk = bclk_gen;
	assign o_bclk_oe = bclk_oe_q;
	assign o_fsync = fs_q;
	assign o_fsync_oe = bclk_oe_q;
	assign o_tx = tx_q;
	assign o_tx_oe = tx_oe_q;

endmodule : vsp_port

// ---- core/vsp_sync.sv ----
// Two-flop synchroniser for quasi-static levels and toggles.
`timescale 1ns/1ps
module vsp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	import vsp_pkg::*;

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// No reset: the destination clock may be stopped while reset is applied.
	always_ff @(posedge i_clk)
	begin
		meta_q <= i_d;
		sync_q <= meta_q;
	end

	assign o_q = sync_q;

endmodule : vsp_sync

// ---- pkg/vsp_consts.svh ----
// Register offsets, field positions, reset values and timing figures of the voice serial port.
`ifndef VSP_CONSTS_SVH
`define VSP_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VSP_OFF_CTRL 8'h00
`define VSP_OFF_FORMAT 8'h04
`define VSP_OFF_TXDATA 8'h08
`define VSP_OFF_RXDATA 8'h0C
`define VSP_OFF_STATUS 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define VSP_CTRL_EN_LSB 0
`define VSP_CTRL_PORT_LSB 2
`define VSP_CTRL_ROLE_BIT 4
`define VSP_FMT_BURST_BIT 0
`define VSP_FMT_EDGE_BIT 1
`define VSP_FMT_WSEL_LSB 2
`define VSP_STAT_ACTIVE_BIT 0
`define VSP_STAT_RXNEW_BIT 1

// ****************************************************************
// Reset values
// ****************************************************************
`define VSP_RST_EN 2'h0
`define VSP_RST_PORT 2'h1
`define VSP_RST_ROLE 1'h1
`define VSP_RST_BURST 1'h1
`define VSP_RST_EDGE 1'h0
`define VSP_RST_WSEL 3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define VSP_SAMPLE_HZ 8000
`define VSP_CLK_HZ 100000000

`endif

// ---- pkg/vsp_pkg.sv ----
// Types shared by the voice serial port modules.
package vsp_pkg;

	typedef enum logic [1:0] {
		VSP_EN_OFF = 2'h0,
		VSP_EN_ON = 2'h1,
		VSP_EN_RSVD = 2'h2
	} vsp_en_t;

	typedef enum logic [2:0] {
		VSP_W16 = 3'h0,
		VSP_W24 = 3'h3,
		VSP_W32 = 3'h4
	} vsp_wsel_t;

	typedef logic [5:0] vsp_cnt_t;

endpackage : vsp_pkg

// ---- test/test_voice_serial_port.sv ----
// Self-checking bench for the voice serial port against a codec model.
`timescale 1ns/1ps
`include "vsp_consts.svh"
module test_voice_serial_port;
	logic i_clk = 1'b0;
	logic lclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata, got;
	logic o_bclk, o_bclk_oe, o_fsync, o_fsync_oe, o_tx, o_tx_oe, c_bclk, c_fsync, c_rx;
	// The codec clocks the idle link from the start, so the link state settles while the port is off.
	logic c_master = 1'b1;
	logic c_burst = 1'b0;
	logic c_cap = 1'b1;
	logic [31:0] c_word = 32'h0;
	wire bclk_w = o_bclk_oe ? o_bclk : c_bclk;
	wire fs_w = o_fsync_oe ? o_fsync : c_fsync;
	int miscompares = 0;
	int n_checks = 0;
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end
	initial
	begin
		#7;
		forever #24 lclk = ~lclk;
	end
	vsp_port uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_bclk(bclk_w), .o_bclk(o_bclk), .o_bclk_oe(o_bclk_oe),
		.i_fsync(fs_w), .o_fsync(o_fsync), .o_fsync_oe(o_fsync_oe), .i_rx(c_rx), .o_tx(o_tx),
		.o_tx_oe(o_tx_oe));
	vsp_codec u_codec (.i_lclk(lclk), .i_master(c_master), .i_burst(c_burst), .i_cap_rise(c_cap),
		.i_word(c_word), .i_bclk(bclk_w), .i_fsync(fs_w), .i_tx(o_tx), .o_bclk(c_bclk),
		.o_fsync(c_fsync), .o_rx(c_rx), .o_got(got));
	task automatic tally_and_finish();
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rdv(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask : rdv
	task automatic poll_rx();
		logic [31:0] v;
		int n;
		v = 32'h0;
		for (n = 0; n < 20000 && v[1] !== 1'b1; n++)
			rdv(`VSP_OFF_STATUS, v);
		if (v[1] !== 1'b1)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask : poll_rx
	// The first word after enable may be misframed, so the second one is judged.
	task automatic run_mode(input logic [4:0] ctrl, input logic [4:0] fmt, input logic [15:0] w);
		logic [31:0] v;
		wr(`VSP_OFF_CTRL, 32'h0);
		c_master <= ~ctrl[4];
		c_burst <= fmt[0];
		c_cap <= ~fmt[0] & ~fmt[1];
		c_word <= {16'h0, ~w};
		wr(`VSP_OFF_FORMAT, {27'h0, fmt});
		wr(`VSP_OFF_TXDATA, {16'h0, w});
		rdv(`VSP_OFF_RXDATA, v);
		wr(`VSP_OFF_CTRL, {27'h0, ctrl});
		repeat (4) @(posedge i_clk);
		check("clock drive", {31'h0, o_bclk_oe}, {31'h0, ctrl[4]});
		check("tx drive", {31'h0, o_tx_oe}, 32'h1);
		poll_rx();
		rdv(`VSP_OFF_RXDATA, v);
		poll_rx();
		rdv(`VSP_OFF_RXDATA, v);
		check("rx word", v, {16'h0, ~w});
		check("tx word", got, {16'h0, w});
	endtask : run_mode
	initial
	begin
		logic [31:0] v;
		logic [4:0] rsvd [3];
		rsvd = '{5'h16, 5'h19, 5'h1D};
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rdv(`VSP_OFF_CTRL, v);
		check("ctrl reset", v, 32'h14);
		rdv(`VSP_OFF_FORMAT, v);
		check("format reset", v, 32'h1);
		rdv(8'h20, v);
		check("unmapped", v, 32'h0);
		check("idle drive", {29'h0, o_bclk_oe, o_fsync_oe, o_tx_oe}, 32'h0);
		foreach (rsvd[i])
		begin
			wr(`VSP_OFF_CTRL, {27'h0, rsvd[i]});
			rdv(`VSP_OFF_CTRL, v);
			check("ctrl stored", v, {27'h0, rsvd[i]});
			check("reserved drive", {30'h0, o_bclk_oe, o_tx_oe}, 32'h0);
		end
		run_mode(5'h15, 5'h00, 16'hA5C3);
		run_mode(5'h15, 5'h01, 16'h3C96);
		run_mode(5'h05, 5'h02, 16'h5A0F);
		run_mode(5'h05, 5'h03, 16'hC381);
		wr(`VSP_OFF_CTRL, 32'h0);
		repeat (40) @(posedge i_clk);
		rdv(`VSP_OFF_RXDATA, v);
		repeat (400) @(posedge i_clk);
		check("off pins", {29'h0, o_tx, o_tx_oe, o_fsync}, 32'h0);
		rdv(`VSP_OFF_STATUS, v);
		check("off status", v, 32'h0);
		tally_and_finish();
	end
endmodule : test_voice_serial_port

// ---- test/vsp_codec.sv ----
// Behavioural audio codec model at the far end of the voice link.
`timescale 1ns/1ps
module vsp_codec (
	input wire logic i_lclk,
	input wire logic i_master,
	input wire logic i_burst,
	input wire logic i_cap_rise,
	input wire logic [31:0] i_word,
	input wire logic i_bclk,
	input wire logic i_fsync,
	input wire logic i_tx,
	output logic o_bclk,
	output logic o_fsync,
	output logic o_rx,
	output logic [31:0] o_got
);
	localparam int W = 16;
	int gcnt = 0;
	int cnt = 0;
	logic fs_prev = 1'b0;
	logic [31:0] sr = 32'h0;
	// A codec acting as clock master runs its clock freely; as a slave it leaves the line low.
	assign o_bclk = i_master & i_lclk;
	always @(i_bclk)
	begin
		if (i_bclk == i_cap_rise)
		begin
			sr <= {sr[30:0], i_tx};
			fs_prev <= i_fsync;
			// A word starts one bit after the frame mark in either format.
			cnt <= (i_burst ? i_fsync : fs_prev & ~i_fsync) ? 0 : cnt + 1;
			if (cnt == W - 1)
				o_got <= {16'h0, sr[14:0], i_tx};
		end
		else
		begin
			o_rx <= i_word[W - 1 - cnt % W];
			if (i_master)
			begin
				gcnt <= (gcnt + 1) % (i_burst ? W : 2 * W);
				o_fsync <= i_burst ? gcnt == W - 1 : gcnt >= W - 1 && gcnt < 2 * W - 1;
			end
		end
	end
endmodule : vsp_codec

// ---- test/vsp_port_props.sv ----
// Checker for the voice serial port register port and link pins.
`timescale 1ns/1ps
`include "vsp_consts.svh"
module vsp_port_props #(
	parameter int CLK_HZ = `VSP_CLK_HZ
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_bclk,
	input wire logic o_bclk,
	input wire logic o_bclk_oe,
	input wire logic i_fsync,
	input wire logic o_fsync,
	input wire logic o_fsync_oe,
	input wire logic i_rx,
	input wire logic o_tx,
	input wire logic o_tx_oe
);
	logic burst_q, burst_d, bclk_q, bclk_d;
	logic [2:0] wsel_q, wsel_d;
	logic [15:0] cnt_q, cnt_d;
	logic [1:0] tg_q, tg_d;
	int half;
	// Half periods are judged only after three toggles, so the start-up edge never counts.
	always_comb
	begin
		burst_d = burst_q;
		wsel_d = wsel_q;
		if (i_wr && i_addr == `VSP_OFF_FORMAT)
		begin
			burst_d = i_wdata[0];
			wsel_d = i_wdata[4:2];
		end
		bclk_d = o_bclk;
		cnt_d = (o_bclk != bclk_q) ? 16'h0 : cnt_q + 16'h1;
		tg_d = !o_bclk_oe ? 2'h0 : tg_q + {1'b0, (o_bclk != bclk_q) && tg_q != 2'h3};
		half = (burst_q ? 2 : 4) * `VSP_SAMPLE_HZ * (wsel_q == 3'h3 ? 24 : wsel_q == 3'h4 ? 32 : 16);
		half = CLK_HZ / half;
	end
	always_ff @(posedge i_clk)
	begin
		burst_q <= !i_rst_n ? `VSP_RST_BURST : burst_d;
		wsel_q <= !i_rst_n ? `VSP_RST_WSEL : wsel_d;
		bclk_q <= bclk_d;
		cnt_q <= cnt_d;
		tg_q <= !i_rst_n ? 2'h0 : tg_d;
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_ctrl(logic [4:0] v);
		i_wr && i_addr == `VSP_OFF_CTRL && i_wdata[4:0] == v;
	endsequence
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero");
	a_unmapped_read: assert property (i_rd && !(i_addr inside {`VSP_OFF_CTRL, `VSP_OFF_FORMAT,
		`VSP_OFF_TXDATA, `VSP_OFF_RXDATA, `VSP_OFF_STATUS}) |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_oe_pair: assert property (o_bclk_oe == o_fsync_oe)
		else $error("clock and frame drive differ");
	a_bclk_rest: assert property (!o_bclk_oe [*4] |-> !o_bclk)
		else $error("bit clock not resting low");
	a_master_on: assert property (s_ctrl(5'h15) |-> ##[1:4] o_bclk_oe && o_tx_oe)
		else $error("master drive missing");
	a_slave_off: assert property (s_ctrl(5'h05) |-> ##4 o_tx_oe && !o_bclk_oe)
		else $error("slave drives clock");
	a_rsvd_quiet: assert property (i_wr && i_addr == `VSP_OFF_CTRL
		&& (i_wdata[1:0] != 2'h1 || i_wdata[3:2] != 2'h1) |-> ##4 !o_tx_oe && !o_bclk_oe)
		else $error("port driving while off");
	a_bclk_half: assert property (o_bclk != bclk_q && tg_q == 2'h3 |-> cnt_q == half - 1)
		else $error("bit clock half period wrong");
	a_fsync_edge: assert property (o_fsync_oe && $past(o_fsync_oe) && $changed(o_fsync)
		|-> $changed(o_bclk))
		else $error("frame sync off clock edge");
endmodule : vsp_port_props
bind vsp_port vsp_port_props #(.CLK_HZ(CLK_HZ)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_bclk(i_bclk), .o_bclk(o_bclk), .o_bclk_oe(o_bclk_oe), .i_fsync(i_fsync),
	.o_fsync(o_fsync), .o_fsync_oe(o_fsync_oe), .i_rx(i_rx), .o_tx(o_tx), .o_tx_oe(o_tx_oe));
